//--- gfx_mem_model.sv
`timescale 1ns/100ps
module gfx_mem_model (
  input  wire gfx_pkg::plane_req_t plane_i,
  input  wire logic                clk_i,
  output logic [31:0]              rdata_o
);
  logic [31:0] mem [0:65535];
  logic [31:0] last_ff = 32'h0;
  // Off-read the bus shows the inverse of the last word, so late sampling
  // in the design reads garbage instead of a lucky stale match
  always_comb rdata_o = plane_i.rd ? mem[plane_i.addr] : ~last_ff;
  always_ff @(posedge clk_i) begin
    if (plane_i.rd) last_ff <= mem[plane_i.addr];
    for (int m = 0; m < 4; m++) begin
      if (plane_i.we[m]) mem[plane_i.addr][8*m +: 8] <=
        plane_i.wdata[8*m +: 8];
    end
  end
endmodule : gfx_mem_model

//--- gfx_pkg.sv
// Behaviour
// RQ1: Compare read returns 1 where maps match.
// RQ2: Cleared participation bit drops map from compare.
// RQ3: Read type picks map byte or compare.
// RQ4: Sequencer chain bit overrides map-select reads.
// RQ5: Read-map field picks map; ignored when comparing.
// RQ6: Odd/even reads use chained pair 0/1, 2/3.
// RQ7: Function field: pass, AND, OR, XOR latches.
// RQ8: Every memory read reloads 32-bit latches.
// RQ9: Rotate write data right by count.
// RQ10: Mode 0: fill bit or rotated data, masked.
// RQ11: Mode 1 writes latches, CPU data ignored.
// RQ12: Mode 2 replicates data bits 3:0 per map.
// RQ13: Mode 3: fill always, mask is rotated&mask.
// RQ14: Mask applies to all maps; 0 keeps latch.
// RQ15: Host reads byte before masked write.
// RQ16: 256-colour bit selects packed shift loading.
// RQ17: Shift format bit interleaves even/odd bits.
// RQ18: Shift registers emit MSB first.
// RQ19: Host odd/even: even address maps 0/2.
// RQ20: Window field decodes four CPU ranges.
// RQ21: Window odd/even swaps address LSB source.
// RQ22: Software matches graphics bit to attribute unit.
// RQ23: Index register low four bits pick register.
// RQ24: Fill-enable field chooses fill per map.
// RQ25: Unused bits read zero, writes ignored.
package gfx_pkg;

  localparam logic [3:0] IDX_FILL      = 4'h0;
  localparam logic [3:0] IDX_FILL_EN   = 4'h1;
  localparam logic [3:0] IDX_CMP_VAL   = 4'h2;
  localparam logic [3:0] IDX_ROTATE_OP = 4'h3;
  localparam logic [3:0] IDX_READ_MAP  = 4'h4;
  localparam logic [3:0] IDX_MODE      = 4'h5;
  localparam logic [3:0] IDX_WINDOW    = 4'h6;
  localparam logic [3:0] IDX_CMP_EN    = 4'h7;
  localparam logic [3:0] IDX_MASK      = 4'h8;

  // Field positions inside the data-port byte
  localparam int ROT_LSB     = 0;
  localparam int FUNC_LSB    = 3;
  localparam int WMODE_LSB   = 0;
  localparam int RDTYPE_BIT  = 3;
  localparam int HOSTOE_BIT  = 4;
  localparam int SHIFTIL_BIT = 5;
  localparam int PACK256_BIT = 6;
  localparam int GFX_BIT     = 0;
  localparam int WINOE_BIT   = 1;
  localparam int WIN_LSB     = 2;

  localparam logic [7:0] MASK_RST = 8'hff;

  // Window bases as 20-bit physical CPU addresses
  localparam logic [19:0] WIN_A000 = 20'ha0000;
  localparam logic [19:0] WIN_B000 = 20'hb0000;
  localparam logic [19:0] WIN_B800 = 20'hb8000;

  typedef enum logic [1:0] {
    FN_PASS, FN_AND, FN_OR, FN_XOR
  } logic_op_t;

  typedef enum logic [1:0] {
    WM_FILL, WM_LATCH, WM_SPREAD, WM_MASKFILL
  } wr_mode_t;

  typedef struct packed {
    logic [3:0] fill;
    logic [3:0] fill_en;
    logic [3:0] cmp_val;
    logic_op_t  func;
    logic [2:0] rot;
    logic [1:0] rd_map;
    logic       pack256;
    logic       shift_il;
    logic       host_oe;
    logic       rd_cmp;
    wr_mode_t   wr_mode;
    logic [1:0] win;
    logic       win_oe;
    logic       gfx;
    logic [3:0] cmp_en;
    logic [7:0] mask;
  } gfx_regs_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic [3:0]  we;
    logic [31:0] wdata;
  } plane_req_t;

endpackage : gfx_pkg

//--- gfx_plane_access.sv
`timescale 1ns/100ps
module gfx_plane_access (
  input  wire logic               clk_i,
  input  wire logic               rstn_i,
  // Indexed register pair: sel 0 = index port, 1 = data port
  input  wire logic               io_wr_i,
  input  wire logic               io_rd_i,
  input  wire logic               io_sel_i,
  input  wire logic [7:0]         io_wdata_i,
  output logic      [7:0]         io_rdata_o,
  // Host memory cycles
  input  wire logic               mem_req_i,
  input  wire logic               mem_we_i,
  input  wire logic [19:0]        mem_addr_i,
  input  wire logic [7:0]         mem_wdata_i,
  output logic                    mem_ready_o,
  output logic                    mem_hit_o,
  output logic                    mem_rvalid_o,
  output logic      [7:0]         mem_rdata_o,
  // Sequencer memory organisation bit 3
  input  wire logic               seq_chain4_i,
  // Display memory maps
  output gfx_pkg::plane_req_t     plane_o,
  input  wire logic [31:0]        plane_rdata_i,
  // Video fetch side
  input  wire logic               vid_load_i,
  input  wire logic               vid_shift_i,
  input  wire logic [31:0]        vid_data_i,
  output logic      [3:0]         vid_pix_o,
  output logic                    gfx_mode_o
);

  typedef enum logic {
    ACC_IDLE,
    ACC_READ
  } acc_state_t;

  // Register file
  gfx_pkg::gfx_regs_t regs_ff;
  gfx_pkg::gfx_regs_t nxt_regs;
  logic [3:0]         index_ff;
  logic [3:0]         nxt_index;
  logic [7:0]         io_rdata_ff;
  logic [7:0]         nxt_io_rdata;

  // Access sequencing
  acc_state_t          state_ff;
  acc_state_t          nxt_state;
  gfx_pkg::plane_req_t plane_ff;
  gfx_pkg::plane_req_t nxt_plane;
  logic [31:0]         latch_ff;
  logic [31:0]         nxt_latch;
  logic [1:0]          rd_map_ff;
  logic [1:0]          nxt_rd_map;
  logic                rd_cmp_ff;
  logic                nxt_rd_cmp;
  logic [7:0]          mem_rdata_ff;
  logic [7:0]          nxt_mem_rdata;
  logic                rvalid_ff;
  logic                nxt_rvalid;

  // Address decode results
  logic        win_hit;
  logic [16:0] win_off;
  logic        host_addr_lsb;
  logic [15:0] disp_addr;
  logic        display_addr_lsb;
  logic [1:0]  acc_map;
  logic [3:0]  acc_we;
  logic        take;
  logic [31:0] wr_data;
  logic [7:0]  cmp_result;

  function automatic logic [7:0] reg_read(input gfx_pkg::gfx_regs_t r,
                                          input logic [3:0] idx);
    logic [7:0] v;
    v = 8'h00; // [RQ25]
    case (idx)
      gfx_pkg::IDX_FILL:      v[3:0] = r.fill;
      gfx_pkg::IDX_FILL_EN:   v[3:0] = r.fill_en;
      gfx_pkg::IDX_CMP_VAL:   v[3:0] = r.cmp_val;
      gfx_pkg::IDX_ROTATE_OP: begin
        v[gfx_pkg::ROT_LSB +: 3]  = r.rot;
        v[gfx_pkg::FUNC_LSB +: 2] = r.func;
      end
      gfx_pkg::IDX_READ_MAP:  v[1:0] = r.rd_map;
      gfx_pkg::IDX_MODE: begin
        v[gfx_pkg::WMODE_LSB +: 2] = r.wr_mode;
        v[gfx_pkg::RDTYPE_BIT]     = r.rd_cmp;
        v[gfx_pkg::HOSTOE_BIT]     = r.host_oe;
        v[gfx_pkg::SHIFTIL_BIT]    = r.shift_il;
        v[gfx_pkg::PACK256_BIT]    = r.pack256;
      end
      gfx_pkg::IDX_WINDOW: begin
        v[gfx_pkg::GFX_BIT]      = r.gfx;
        v[gfx_pkg::WINOE_BIT]    = r.win_oe;
        v[gfx_pkg::WIN_LSB +: 2] = r.win;
      end
      gfx_pkg::IDX_CMP_EN:    v[3:0] = r.cmp_en;
      gfx_pkg::IDX_MASK:      v = r.mask;
      default:                v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  // Returns {hit, offset from window base}
  function automatic logic [17:0] win_decode(input logic [1:0]  win,
                                             input logic [19:0] a);
    logic [17:0] res;
    logic [19:0] d;
    res = 18'h0_0000;
    d   = 20'h0_0000;
    case (win) // [RQ20]
      2'b00: begin
        d   = a - gfx_pkg::WIN_A000;
        res = {(a[19:17] == gfx_pkg::WIN_A000[19:17]), d[16:0]};
      end
      2'b01: begin
        d   = a - gfx_pkg::WIN_A000;
        res = {(a[19:16] == gfx_pkg::WIN_A000[19:16]), 1'b0, d[15:0]};
      end
      2'b10: begin
        d   = a - gfx_pkg::WIN_B000;
        res = {(a[19:15] == gfx_pkg::WIN_B000[19:15]), 2'b00, d[14:0]};
      end
      default: begin
        d   = a - gfx_pkg::WIN_B800;
        res = {(a[19:15] == gfx_pkg::WIN_B800[19:15]), 2'b00, d[14:0]};
      end
    endcase
    return res;
  endfunction : win_decode

  // Register port
  always_comb begin
    nxt_regs     = regs_ff;
    nxt_index    = index_ff;
    nxt_io_rdata = io_rdata_ff;
    if (io_rd_i)
      nxt_io_rdata = io_sel_i ? reg_read(regs_ff, index_ff)
                              : {4'h0, index_ff}; // [RQ25]
    if (io_wr_i && !io_sel_i)
      nxt_index = io_wdata_i[3:0]; // [RQ23]
    else if (io_wr_i) begin
      // Only defined bits are stored [RQ25]
      case (index_ff) // [RQ23]
        gfx_pkg::IDX_FILL:      nxt_regs.fill    = io_wdata_i[3:0];
        gfx_pkg::IDX_FILL_EN:   nxt_regs.fill_en = io_wdata_i[3:0]; // [RQ24]
        gfx_pkg::IDX_CMP_VAL:   nxt_regs.cmp_val = io_wdata_i[3:0];
        gfx_pkg::IDX_ROTATE_OP: begin
          nxt_regs.rot  = io_wdata_i[gfx_pkg::ROT_LSB +: 3];
          nxt_regs.func = gfx_pkg::logic_op_t'(
                            io_wdata_i[gfx_pkg::FUNC_LSB +: 2]);
        end
        gfx_pkg::IDX_READ_MAP:  nxt_regs.rd_map = io_wdata_i[1:0];
        gfx_pkg::IDX_MODE: begin
          nxt_regs.wr_mode  = gfx_pkg::wr_mode_t'(
                                io_wdata_i[gfx_pkg::WMODE_LSB +: 2]);
          nxt_regs.rd_cmp   = io_wdata_i[gfx_pkg::RDTYPE_BIT];
          nxt_regs.host_oe  = io_wdata_i[gfx_pkg::HOSTOE_BIT];
          nxt_regs.shift_il = io_wdata_i[gfx_pkg::SHIFTIL_BIT];
          nxt_regs.pack256  = io_wdata_i[gfx_pkg::PACK256_BIT];
        end
        gfx_pkg::IDX_WINDOW: begin
          nxt_regs.gfx    = io_wdata_i[gfx_pkg::GFX_BIT];
          nxt_regs.win_oe = io_wdata_i[gfx_pkg::WINOE_BIT];
          nxt_regs.win    = io_wdata_i[gfx_pkg::WIN_LSB +: 2];
        end
        gfx_pkg::IDX_CMP_EN:    nxt_regs.cmp_en = io_wdata_i[3:0];
        gfx_pkg::IDX_MASK:      nxt_regs.mask   = io_wdata_i;
        default:                nxt_regs = regs_ff;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      regs_ff      <= '0;
      regs_ff.mask <= gfx_pkg::MASK_RST;
      index_ff     <= 4'h0;
      io_rdata_ff  <= 8'h00;
    end else begin
      regs_ff     <= nxt_regs;
      index_ff    <= nxt_index;
      io_rdata_ff <= nxt_io_rdata;
    end
  end

  // Host address to map address and map choice
  always_comb begin
    {win_hit, win_off} = win_decode(regs_ff.win, mem_addr_i);
    host_addr_lsb      = win_off[0];
    if (seq_chain4_i) begin
      // Chained four-map mode: low bits pick the map [RQ4]
      disp_addr = {1'b0, win_off[16:2]};
      acc_map   = win_off[1:0];
      acc_we    = 4'b0001 << win_off[1:0];
    end else if (regs_ff.win_oe || regs_ff.host_oe) begin
      // Higher bit replaces the LSB only for window odd/even [RQ21]
      disp_addr = regs_ff.win_oe ? {win_off[15:1], win_off[16]}
                                 : win_off[15:0];
      acc_map   = {regs_ff.rd_map[1], host_addr_lsb}; // [RQ6] [RQ19]
      acc_we    = host_addr_lsb ? 4'b1010 : 4'b0101; // [RQ19] [RQ21]
    end else begin
      disp_addr = win_off[15:0];
      acc_map   = regs_ff.rd_map; // [RQ5]
      acc_we    = 4'b1111;
    end
    display_addr_lsb = disp_addr[0];
  end

  assign mem_hit_o   = win_hit;
  assign mem_ready_o = (state_ff == ACC_IDLE);
  assign take        = mem_req_i && mem_ready_o && win_hit;

  gfx_write_unit u_write (
    .regs_i     (regs_ff),
    .cpu_data_i (mem_wdata_i),
    .latch_i    (latch_ff),
    .wdata_o    (wr_data)
  );

  // Each bit is 1 where every participating map equals its value
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      cmp_result[b] = 1'b1;
      for (int m = 0; m < 4; m++) begin
        if (regs_ff.cmp_en[m] &&
            (plane_rdata_i[8*m + b] != regs_ff.cmp_val[m])) // [RQ2]
          cmp_result[b] = 1'b0; // [RQ1]
      end
    end
  end

  // Access sequencing
  always_comb begin
    nxt_state     = state_ff;
    nxt_plane     = plane_ff;
    nxt_latch     = latch_ff;
    nxt_rd_map    = rd_map_ff;
    nxt_rd_cmp    = rd_cmp_ff;
    nxt_mem_rdata = mem_rdata_ff;
    nxt_rvalid    = 1'b0;
    nxt_plane.rd  = 1'b0;
    nxt_plane.we  = 4'h0;
    case (state_ff)
      ACC_IDLE: begin
        if (take) begin
          nxt_plane.addr = {disp_addr[15:1], display_addr_lsb};
          if (mem_we_i) begin
            nxt_plane.we    = acc_we;
            nxt_plane.wdata = wr_data;
          end else begin
            nxt_plane.rd = 1'b1;
            nxt_rd_map   = acc_map;
            nxt_rd_cmp   = regs_ff.rd_cmp;
            nxt_state    = ACC_READ;
          end
        end
      end
      ACC_READ: begin
        nxt_latch = plane_rdata_i; // [RQ8]
        // Compare result ignores the map field [RQ3] [RQ5]
        nxt_mem_rdata = rd_cmp_ff ? cmp_result
                                  : plane_rdata_i[8*rd_map_ff +: 8]; // [RQ3]
        nxt_rvalid    = 1'b1;
        nxt_state     = ACC_IDLE;
      end
      default: nxt_state = ACC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff     <= ACC_IDLE;
      plane_ff     <= '0;
      latch_ff     <= 32'h0000_0000;
      rd_map_ff    <= 2'b00;
      rd_cmp_ff    <= 1'b0;
      mem_rdata_ff <= 8'h00;
      rvalid_ff    <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      plane_ff     <= nxt_plane;
      latch_ff     <= nxt_latch;
      rd_map_ff    <= nxt_rd_map;
      rd_cmp_ff    <= nxt_rd_cmp;
      mem_rdata_ff <= nxt_mem_rdata;
      rvalid_ff    <= nxt_rvalid;
    end
  end

  assign plane_o      = plane_ff;
  assign mem_rdata_o  = mem_rdata_ff;
  assign mem_rvalid_o = rvalid_ff;
  assign io_rdata_o   = io_rdata_ff;
  // Must agree with the attribute unit's bit; not checked here
  assign gfx_mode_o   = regs_ff.gfx; // [RQ22]

  video_shift_loader u_shift (
    .clk_i        (clk_i),
    .rstn_i       (rstn_i),
    .load_i       (vid_load_i),
    .shift_i      (vid_shift_i),
    .pack256_i    (regs_ff.pack256),
    .interleave_i (regs_ff.shift_il),
    .data_i       (vid_data_i),
    .pix_o        (vid_pix_o)
  );

endmodule : gfx_plane_access

//--- gfx_plane_access_monitor.sv
`timescale 1ns/100ps
module gfx_plane_access_monitor (
  input wire logic                clk_i,
  input wire logic                rstn_i,
  input wire logic                mem_req_i,
  input wire logic                mem_we_i,
  input wire logic [19:0]         mem_addr_i,
  input wire logic                mem_ready_o,
  input wire logic                mem_hit_o,
  input wire logic                mem_rvalid_o,
  input wire logic [7:0]          mem_rdata_o,
  input wire gfx_pkg::plane_req_t plane_o,
  input wire logic                vid_load_i,
  input wire logic                vid_shift_i,
  input wire logic [31:0]         vid_data_i,
  input wire logic [3:0]          vid_pix_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic take;
  assign take = mem_req_i && mem_ready_o && mem_hit_o;
  read_pipe_a: assert property (
    take && !mem_we_i |=> plane_o.rd && !mem_ready_o ##1 mem_rvalid_o)
    else $error("read answer out of order");
  write_lane_a: assert property (
    take && mem_we_i |=> plane_o.we != 4'h0 && !plane_o.rd)
    else $error("taken write reached no map");
  miss_idle_a: assert property (
    mem_req_i && mem_ready_o && !mem_hit_o |=> !plane_o.we && !plane_o.rd)
    else $error("request outside window reached maps");
  range_hit_a: assert property (
    mem_addr_i < 20'ha0000 || mem_addr_i > 20'hbffff |-> !mem_hit_o)
    else $error("hit outside every window");
  rvalid_once_a: assert property (
    mem_rvalid_o |=> !mem_rvalid_o)
    else $error("read valid longer than one cycle");
  rdata_hold_a: assert property (
    !mem_rvalid_o |-> $stable(mem_rdata_o))
    else $error("read data changed without valid");
  rd_no_we_a: assert property (
    plane_o.rd |-> plane_o.we == 4'h0)
    else $error("read and write in one cycle");
  vid_flat_a: assert property (
    vid_load_i && (vid_data_i == 32'h0 || vid_data_i == 32'hffffffff)
    |=> vid_pix_o == {4{$past(vid_data_i[0])}})
    else $error("uniform load gave mixed pixels");
  vid_hold_a: assert property (
    !vid_load_i && !vid_shift_i |=> $stable(vid_pix_o))
    else $error("pixels moved without shift");
endmodule : gfx_plane_access_monitor

bind gfx_plane_access gfx_plane_access_monitor mon_u (
  .clk_i(clk_i), .rstn_i(rstn_i), .mem_req_i(mem_req_i),
  .mem_we_i(mem_we_i), .mem_addr_i(mem_addr_i),
  .mem_ready_o(mem_ready_o), .mem_hit_o(mem_hit_o),
  .mem_rvalid_o(mem_rvalid_o), .mem_rdata_o(mem_rdata_o),
  .plane_o(plane_o), .vid_load_i(vid_load_i), .vid_shift_i(vid_shift_i),
  .vid_data_i(vid_data_i), .vid_pix_o(vid_pix_o));

//--- gfx_plane_access_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module gfx_plane_access_tb;
  logic                clk_i = 1'b0;
  logic                rstn_i, io_wr_i, io_rd_i, io_sel_i, mem_req_i;
  logic                mem_we_i, mem_ready_o, mem_hit_o, mem_rvalid_o;
  logic                seq_chain4_i, vid_load_i, vid_shift_i, gfx_mode_o;
  logic [7:0]          io_wdata_i, io_rdata_o, mem_wdata_i, mem_rdata_o, r;
  logic [19:0]         mem_addr_i;
  logic [31:0]         plane_rdata_i, vid_data_i;
  logic [3:0]          vid_pix_o;
  gfx_pkg::plane_req_t plane_o;
  int                  err_total = 0;
  int                  n_compared = 0;
  localparam logic [7:0] wm [10] = '{8'h0f, 8'h0f, 8'h0f, 8'h1f, 8'h03,
                                     8'h7b, 8'h0f, 8'h0f, 8'hff, 8'h00};
  localparam logic [7:0] fx [4] = '{8'hc0, 8'hc0, 8'hf0, 8'h30};
  localparam logic [15:0] cmp_t [6] = '{16'h5ff3, 16'h9f0c, 16'h11ff,
                                        16'h0100, 16'h00ff, 16'h880c};
  always #25 clk_i = ~clk_i;
  gfx_plane_access dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
    .io_sel_i(io_sel_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .mem_req_i(mem_req_i), .mem_we_i(mem_we_i), .mem_addr_i(mem_addr_i),
    .mem_wdata_i(mem_wdata_i), .mem_ready_o(mem_ready_o),
    .mem_hit_o(mem_hit_o), .mem_rvalid_o(mem_rvalid_o),
    .mem_rdata_o(mem_rdata_o), .seq_chain4_i(seq_chain4_i),
    .plane_o(plane_o), .plane_rdata_i(plane_rdata_i),
    .vid_load_i(vid_load_i), .vid_shift_i(vid_shift_i),
    .vid_data_i(vid_data_i), .vid_pix_o(vid_pix_o), .gfx_mode_o(gfx_mode_o));
  gfx_mem_model mem_u (.clk_i(clk_i), .plane_i(plane_o),
                       .rdata_o(plane_rdata_i));
  task reg_wr(input logic [3:0] i, input logic [7:0] v);
    io_sel_i   <= 1'b0;
    io_wdata_i <= {4'h0, i};
    io_wr_i    <= 1'b1;
    @(posedge clk_i);
    io_sel_i   <= 1'b1;
    io_wdata_i <= v;
    @(posedge clk_i);
    io_wr_i    <= 1'b0;
    @(posedge clk_i);
  endtask : reg_wr
  task reg_rd(input logic [3:0] i, output logic [7:0] v, input logic s = 1);
    io_sel_i   <= 1'b0;
    io_wdata_i <= {4'h0, i};
    io_wr_i    <= 1'b1;
    @(posedge clk_i);
    io_wr_i    <= 1'b0;
    io_rd_i    <= 1'b1;
    io_sel_i   <= s;
    @(posedge clk_i);
    io_rd_i    <= 1'b0;
    @(posedge clk_i);
    v = io_rdata_o;
  endtask : reg_rd
  task mem_wr(input logic [19:0] a, input logic [7:0] d);
    {mem_req_i, mem_we_i} <= 2'b11;
    mem_addr_i  <= a;
    mem_wdata_i <= d;
    @(posedge clk_i);
    mem_req_i   <= 1'b0;
    @(posedge clk_i);
  endtask : mem_wr
  task mem_rd(input logic [19:0] a, output logic [7:0] v);
    {mem_req_i, mem_we_i} <= 2'b10;
    mem_addr_i <= a;
    @(posedge clk_i);
    mem_req_i  <= 1'b0;
    for (int k = 0; k < 4 && mem_rvalid_o !== 1'b1; k++) @(negedge clk_i);
    `CHK(mem_rvalid_o, 1'b1)
    v = mem_rdata_o;
    @(posedge clk_i);
  endtask : mem_rd
  task chk_maps(input logic [19:0] a, input logic [31:0] e);
    logic [7:0] v;
    for (int m = 0; m < 4; m++) begin
      reg_wr(4'h4, m[7:0]);
      mem_rd(a, v);
      `CHK(v, e[8*m +: 8])
    end
  endtask : chk_maps
  task wr_probe(input logic [19:0] a, logic [3:0] we, logic [15:0] ad);
    {mem_req_i, mem_we_i} <= 2'b11;
    mem_addr_i <= a;
    @(posedge clk_i);
    mem_req_i  <= 1'b0;
    @(negedge clk_i);
    `CHK(plane_o.we, we)
    `CHK(plane_o.addr, ad)
    @(posedge clk_i);
  endtask : wr_probe
  function automatic logic [3:0] exp_pix(input logic [7:0] md,
                                         input logic [31:0] d, input int k);
    logic [3:0] p;
    for (int q = 0; q < 4; q++) begin
      if (md[6]) p[q] = d[8*(k/2) + 4*(1-k%2) + q];
      else if (md[5]) p[q] = d[8*((q/2)*2 + k/4) + 7 - 2*(k%4) - (1-q%2)];
      else p[q] = d[8*q + 7 - k];
    end
    return p;
  endfunction : exp_pix
  task t_regs;
    for (int i = 0; i < 10; i++) begin
      reg_rd(i[3:0], r);
      `CHK(r, i == 8 ? 8'hff : 8'h00)
      reg_wr(i[3:0], 8'hff);
      reg_rd(i[3:0], r);
      `CHK(r, wm[i])
      reg_wr(i[3:0], i == 8 ? 8'hff : 8'h00);
    end
    reg_rd(4'h7, r, 1'b0);
    `CHK(r, 8'h07)
  endtask : t_regs
  task t_write;
    reg_wr(4'h1, 8'h0f);
    reg_wr(4'h0, 8'h05);
    mem_wr(20'ha0010, 8'h00);
    chk_maps(20'ha0010, 32'h00ff00ff);
    reg_wr(4'h1, 8'h03);
    mem_wr(20'ha0011, 8'h5a);
    chk_maps(20'ha0011, 32'h5a5a00ff);
    reg_wr(4'h1, 8'h00);
    reg_wr(4'h0, 8'h00);
    reg_wr(4'h4, 8'h00);
    for (int f = 0; f < 4; f++) begin
      reg_wr(4'h3, 8'h00);
      mem_wr(20'ha0020, 8'hf0);
      mem_rd(20'ha0020, r);
      reg_wr(4'h3, {3'h0, f[1:0], 3'd1});
      mem_wr(20'ha0020, 8'h81);
      mem_rd(20'ha0020, r);
      `CHK(r, fx[f])
    end
    reg_wr(4'h3, 8'h00);
    mem_wr(20'ha0020, 8'hf0);
    mem_rd(20'ha0020, r);
    reg_wr(4'h8, 8'h3c);
    mem_wr(20'ha0020, 8'h00);
    reg_wr(4'h8, 8'hff);
    chk_maps(20'ha0020, {4{8'hc0}});
  endtask : t_write
  task t_modes;
    mem_rd(20'ha0010, r);
    reg_wr(4'h5, 8'h01);
    mem_wr(20'ha0030, 8'h12);
    chk_maps(20'ha0030, 32'h00ff00ff);
    reg_wr(4'h5, 8'h02);
    mem_wr(20'ha0040, 8'h06);
    chk_maps(20'ha0040, 32'h00ffff00);
    mem_rd(20'ha0010, r);
    reg_wr(4'h5, 8'h03);
    reg_wr(4'h0, 8'h09);
    reg_wr(4'h8, 8'h3c);
    mem_wr(20'ha0050, 8'h0f);
    reg_wr(4'h8, 8'hff);
    reg_wr(4'h5, 8'h00);
    reg_wr(4'h0, 8'h00);
    chk_maps(20'ha0050, 32'h0cf300ff);
  endtask : t_modes
  task t_read;
    reg_wr(4'h5, 8'h08);
    for (int k = 0; k < 6; k++) begin
      reg_wr(4'h2, {4'h0, cmp_t[k][15:12]});
      reg_wr(4'h7, {4'h0, cmp_t[k][11:8]});
      mem_rd(20'ha0050, r);
      `CHK(r, cmp_t[k][7:0])
    end
    reg_wr(4'h5, 8'h00);
    seq_chain4_i <= 1'b1;
    mem_wr(20'ha0101, 8'h77);
    reg_wr(4'h4, 8'h00);
    mem_rd(20'ha0101, r);
    `CHK(r, 8'h77)
    seq_chain4_i <= 1'b0;
    reg_wr(4'h5, 8'h10);
    mem_wr(20'ha0201, 8'h33);
    mem_wr(20'ha0200, 8'h44);
    reg_wr(4'h4, 8'h02);
    mem_rd(20'ha0201, r);
    `CHK(r, 8'h33)
    mem_rd(20'ha0200, r);
    `CHK(r, 8'h44)
    reg_wr(4'h4, 8'h01);
    mem_rd(20'ha0200, r);
    `CHK(r, 8'h44)
    reg_wr(4'h5, 8'h00);
    reg_wr(4'h6, 8'h02);
    wr_probe(20'ha0203, 4'ha, 16'h0202);
    wr_probe(20'hb0202, 4'h5, 16'h0203);
  endtask : t_read
  task t_window;
    logic [19:0] pa [4];
    pa = '{20'haffff, 20'hb0000, 20'hb8000, 20'hc0000};
    for (int w = 0; w < 4; w++) begin
      reg_wr(4'h6, {4'h0, w[1:0], 2'b01});
      `CHK(gfx_mode_o, 1'b1)
      for (int j = 0; j < 4; j++) begin
        mem_addr_i <= pa[j];
        @(negedge clk_i);
        `CHK(mem_hit_o, 16'he842 >> (15 - 4*w - j) & 1'b1)
        @(posedge clk_i);
      end
    end
    reg_wr(4'h6, 8'h00);
    `CHK(gfx_mode_o, 1'b0)
    mem_wr(20'hc0010, 8'h99);
    mem_rd(20'ha0010, r);
    `CHK(r, 8'h00)
  endtask : t_window
  task t_video;
    logic [7:0] md [3];
    md = '{8'h00, 8'h20, 8'h40};
    for (int i = 0; i < 4; i++) begin
      if (i < 3) reg_wr(4'h5, md[i]);
      vid_data_i <= i < 3 ? 32'h96e14b3c : 32'hffffffff;
      vid_load_i <= 1'b1;
      @(posedge clk_i);
      vid_load_i  <= 1'b0;
      vid_shift_i <= 1'b1;
      for (int k = 0; k < 8; k++) begin
        @(negedge clk_i);
        `CHK(vid_pix_o, exp_pix(md[i%3], vid_data_i, k))
        @(posedge clk_i);
      end
      vid_shift_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask : t_video
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  initial begin
    // Generous: the sequence needs well under a thousand cycles
    #1000000;
    err_total++;
    finish_test();
  end
  initial begin
    {rstn_i, io_wr_i, io_rd_i, io_sel_i, mem_req_i, mem_we_i} = 6'h0;
    {seq_chain4_i, vid_load_i, vid_shift_i} = 3'h0;
    {io_wdata_i, mem_wdata_i, mem_addr_i, vid_data_i} = 68'h0;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_write();
    t_modes();
    t_read();
    t_window();
    t_video();
    finish_test();
  end
endmodule : gfx_plane_access_tb

//--- gfx_write_unit.sv
`timescale 1ns/100ps
module gfx_write_unit (
  input  wire gfx_pkg::gfx_regs_t regs_i,
  input  wire logic [7:0]         cpu_data_i,
  input  wire logic [31:0]        latch_i,
  output logic      [31:0]        wdata_o
);

  logic [7:0] rot;
  logic [7:0] mask;

  function automatic logic [7:0] rotr(input logic [7:0] d,
                                      input logic [2:0] n);
    logic [15:0] w;
    w = {d, d} >> n;
    return w[7:0];
  endfunction : rotr

  always_comb begin
    rot = rotr(cpu_data_i, regs_i.rot); // [RQ9]
    if (regs_i.wr_mode == gfx_pkg::WM_MASKFILL)
      mask = rot & regs_i.mask; // [RQ13]
    else if (regs_i.wr_mode == gfx_pkg::WM_LATCH)
      mask = 8'hff;
    else
      mask = regs_i.mask; // [RQ14]
  end

  genvar m;
  generate
    for (m = 0; m < 4; m++) begin : g_map
      logic [7:0] lat;
      logic [7:0] src;
      logic [7:0] alu;
      assign lat = latch_i[8*m +: 8];
      always_comb begin
        case (regs_i.wr_mode)
          gfx_pkg::WM_FILL: // [RQ10] [RQ24]
            src = regs_i.fill_en[m] ? {8{regs_i.fill[m]}} : rot;
          gfx_pkg::WM_LATCH:   src = lat; // [RQ11]
          gfx_pkg::WM_SPREAD:  src = {8{cpu_data_i[m]}}; // [RQ12]
          default:             src = {8{regs_i.fill[m]}}; // [RQ13]
        endcase
        if (regs_i.wr_mode == gfx_pkg::WM_LATCH)
          alu = src;
        else begin
          case (regs_i.func) // [RQ7]
            gfx_pkg::FN_AND: alu = src & lat;
            gfx_pkg::FN_OR:  alu = src | lat;
            gfx_pkg::FN_XOR: alu = src ^ lat;
            default:         alu = src;
          endcase
        end
      end
      // Unmasked bits restore the latched byte [RQ14]
      assign wdata_o[8*m +: 8] = (alu & mask) | (lat & ~mask);
    end
  endgenerate

endmodule : gfx_write_unit

//--- video_shift_loader.sv
`timescale 1ns/100ps
module video_shift_loader (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        load_i,
  input  wire logic        shift_i,
  input  wire logic        pack256_i,
  input  wire logic        interleave_i,
  input  wire logic [31:0] data_i,
  output logic      [3:0]  pix_o
);

  logic [31:0] sreg_ff;
  logic [31:0] nxt_sreg;
  logic [31:0] loaded;

  // Shift position s (0 emitted first) of register r
  function automatic logic load_bit(input logic [31:0] d,
                                    input logic p256,
                                    input logic il,
                                    input int r,
                                    input int s);
    logic b;
    if (p256)
      // Nibble stream: map s/2, high nibble first
      b = d[8*(s/2) + ((s%2 == 0) ? 4 : 0) + r];
    else if (il)
      // Bit pairs: odd bits to odd regs, even to even
      b = d[8*((r/2)*2 + s/4) + 7 - 2*(s%4) - ((r%2 == 0) ? 1 : 0)];
    else
      b = d[8*r + 7 - s];
    return b;
  endfunction : load_bit

  genvar r, s;
  generate
    for (r = 0; r < 4; r++) begin : g_reg
      for (s = 0; s < 8; s++) begin : g_pos
        assign loaded[8*r + 7 - s] =
          load_bit(data_i, pack256_i, interleave_i, r, s); // [RQ16] [RQ17]
      end
    end
  endgenerate

  always_comb begin
    nxt_sreg = sreg_ff;
    if (load_i)
      nxt_sreg = loaded;
    else if (shift_i) begin
      for (int i = 0; i < 4; i++)
        nxt_sreg[8*i +: 8] = {sreg_ff[8*i +: 7], 1'b0};
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      sreg_ff <= 32'h0000_0000;
    else
      sreg_ff <= nxt_sreg;
  end

  // MSB of each register is the current pixel bit [RQ18]
  assign pix_o = {sreg_ff[31], sreg_ff[23], sreg_ff[15], sreg_ff[7]};

endmodule : video_shift_loader
